// file: rtl/sru_pkg.sv
package sru_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADR_W  = 8;
  localparam int unsigned DAT_W  = 32;
  localparam int unsigned REG_W  = 8;

  // ---------------------------------------------------------------
  // Whole-register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS    = 8'h00;
  localparam logic [7:0] OFF_SRE       = 8'h04;
  localparam logic [7:0] OFF_ESR       = 8'h08;
  localparam logic [7:0] OFF_ESE       = 8'h0C;
  localparam logic [7:0] OFF_COMM_ERROR_EVENT_REG      = 8'h10;
  localparam logic [7:0] OFF_COMM_ERROR_EVENT_MASK      = 8'h14;
  localparam logic [7:0] OFF_PULSE     = 8'h18;
  localparam logic [7:0] OFF_CLEAR     = 8'h1C;

  // ---------------------------------------------------------------
  // Bit-indexed windows: eight words each, word i is bit i
  // ---------------------------------------------------------------
  localparam logic [2:0] WIN_STATUS    = 3'h1;
  localparam logic [2:0] WIN_ESR       = 3'h2;
  localparam logic [2:0] WIN_COMM_ERROR_EVENT_REG      = 3'h3;
  localparam logic [2:0] WIN_SRE       = 3'h4;
  localparam logic [2:0] WIN_ESE       = 3'h5;
  localparam logic [2:0] WIN_COMM_ERROR_EVENT_MASK      = 3'h6;

  // ---------------------------------------------------------------
  // Status byte layout
  // ---------------------------------------------------------------
  localparam int unsigned STB_CES_BIT  = 3;
  localparam int unsigned STB_ESB_BIT  = 5;
  localparam int unsigned STB_MSS_BIT  = 6;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MASK      = 8'h00;
  localparam logic       RST_PULSE     = 1'b0;
  localparam logic       PULSE_OFF     = 1'b0;
  localparam logic       PULSE_ON      = 1'b1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned PULSE_MIN_NS   = 1000;
  localparam int unsigned PULSE_CYCLES   = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CNT_W    = 8;

  typedef enum logic [1:0] {
    SRU_REQ_IDLE  = 2'b00,
    SRU_REQ_LATCH = 2'b01,
    SRU_REQ_PULSE = 2'b10
  } sru_req_t;

endpackage

// file: rtl/sru_top.sv
`timescale 1ns/1ns
`default_nettype none

module sru_top
  import sru_pkg::*;
#(
  parameter int unsigned PULSE_LEN = sru_pkg::PULSE_CYCLES
)(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [sru_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [sru_pkg::DAT_W-1:0] wb_dat_i,
  output var  logic [sru_pkg::DAT_W-1:0] wb_dat_o,
  output var  logic                      wb_ack_o,
  input  wire logic [sru_pkg::REG_W-1:0] dev_status_i,
  input  wire logic [sru_pkg::REG_W-1:0] std_event_i,
  input  wire logic [sru_pkg::REG_W-1:0] comm_event_i,
  output var  logic                      service_request_n_o,
  output var  logic                      request_pulse_mode_o
);
  import sru_pkg::*;

  // -------------------------------------------------------------
  // Elaboration check
  // -------------------------------------------------------------
  // The pulse timer is PULSE_CNT_W bits wide; longer pulses would wrap
  if (PULSE_LEN < 1 || PULSE_LEN > (1 << PULSE_CNT_W) - 1) begin : g_bad_pulse_len
    $error("PULSE_LEN must be 1 to 255");
  end

  // -------------------------------------------------------------
  // Limitations
  // -------------------------------------------------------------
  // Bit indices are three bits wide: no invalid index, no error raised.
  // Requests arising during a pulse are dropped, not queued.
  // A mode change leaves a request already latched or pulsing alone.
  // Unmapped or misaligned accesses are acked and read zero.
  // Only byte lane 0 carries data; every register is one byte, except pulse mode, which is bit 0.
  // Event inputs OR in every cycle; a held input re-sets a cleared bit.

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  // Software-visible registers, one byte each except the one-bit pulse mode
  logic [REG_W-1:0]       sre_mask;
  logic [REG_W-1:0]       std_event_reg;
  logic [REG_W-1:0]       std_event_mask;
  logic [REG_W-1:0]       comm_error_event_reg;
  logic [REG_W-1:0]       comm_error_event_mask;
  logic                   request_pulse_mode;
  // Request sequencing: enabled bits seen last cycle, state, pulse timer
  logic [REG_W-1:0]       armed_q;
  sru_req_t               req_state;
  sru_req_t               next_req_state;
  logic [PULSE_CNT_W-1:0] pulse_cnt;
  logic [PULSE_CNT_W-1:0] next_pulse_cnt;

  // -------------------------------------------------------------
  // Bus decode
  // -------------------------------------------------------------
  // Map, byte offsets, each register in bits 7:0 of its word:
  //   00 status byte, read releases the request line
  //   04 request enable mask
  //   08 standard event register, read clears all
  //   0C standard event enable mask
  //   10 comm error event register, read clears all
  //   14 comm error event mask
  //   18 pulse mode, bit 0
  //   1C clear status, any write with byte lane 0 on
  // Bit windows of eight words, word i is bit i, per-bit writes use bit 0:
  //   20 status bit, no release; 40 standard event bit, read clears it
  //   60 comm error bit, read clears it; 80 request enable bit
  //   A0 standard event enable bit; C0 comm error mask bit; E0 unmapped
  // Taken once: the ack cycle itself never counts as a new access
  wire              take       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire              rd         = take & ~wb_we_i;
  wire              wr         = take & wb_we_i & wb_sel_i[0];
  // Misaligned addresses hit nothing, so they read zero and write nothing
  wire [7:0]        adr        = wb_adr_i;
  wire              word_ok    = (adr[1:0] == 2'b00);
  wire [2:0]        win        = adr[7:5];
  wire [2:0]        bit_idx    = adr[4:2];
  wire              in_win     = word_ok & (win != 3'h0);

  // -------------------------------------------------------------
  // Whole-register hits
  // -------------------------------------------------------------
  wire              hit_status = word_ok & (adr == OFF_STATUS);
  wire              hit_sre    = word_ok & (adr == OFF_SRE);
  wire              hit_esr    = word_ok & (adr == OFF_ESR);
  wire              hit_ese    = word_ok & (adr == OFF_ESE);
  wire              hit_comm_error_event_reg   = word_ok & (adr == OFF_COMM_ERROR_EVENT_REG);
  wire              hit_comm_error_event_mask   = word_ok & (adr == OFF_COMM_ERROR_EVENT_MASK);
  wire              hit_pulse  = word_ok & (adr == OFF_PULSE);
  wire              hit_clear  = word_ok & (adr == OFF_CLEAR);

  // -------------------------------------------------------------
  // Bit windows
  // -------------------------------------------------------------
  // Upper three address bits pick the register, the next three the bit
  wire              w_status   = in_win & (win == WIN_STATUS);
  wire              w_esr      = in_win & (win == WIN_ESR);
  wire              w_comm_error_event_reg     = in_win & (win == WIN_COMM_ERROR_EVENT_REG);
  wire              w_sre      = in_win & (win == WIN_SRE);
  wire              w_ese      = in_win & (win == WIN_ESE);
  wire              w_comm_error_event_mask     = in_win & (win == WIN_COMM_ERROR_EVENT_MASK);
  // One-hot bit select, shared by read-clears and per-bit writes
  wire [REG_W-1:0]  idx_onehot = 8'h01 << bit_idx;
  wire              wr_bit     = wb_dat_i[0];
  // Windows hold eight words, so no index above 7 can be formed
  wire              idx_valid  = (bit_idx <= 3'h7);

  // -------------------------------------------------------------
  // Status byte composition
  // -------------------------------------------------------------
  // A summary follows its register live, not only when an event arrives
  // Summary bits are live; the request bit is the OR of enabled others
  wire             esb_sum = |(std_event_reg & std_event_mask);
  wire             ces_sum = |(comm_error_event_reg & comm_error_event_mask);
  // Positions 3, 5 and 6 belong to this block; the rest pass through
  logic [REG_W-1:0] stb_base;
  always_comb begin
    stb_base               = dev_status_i;
    stb_base[STB_ESB_BIT]  = esb_sum;
    stb_base[STB_CES_BIT]  = ces_sum;
    stb_base[STB_MSS_BIT]  = 1'b0;
  end
  // Bit 6 is never enabled, so the request summary cannot hold itself up
  wire [REG_W-1:0] sre_eff    = sre_mask & ~(8'h01 << STB_MSS_BIT);
  wire             mss        = |(stb_base & sre_eff);
  wire [REG_W-1:0] status_byte = stb_base | ({7'h00, mss} << STB_MSS_BIT);

  // A bit that rises under its enable asks for service
  // Levels alone would re-raise after every release; only a rise counts
  wire [REG_W-1:0] armed    = stb_base & sre_eff;
  wire             new_req  = |(armed & ~armed_q);

  // -------------------------------------------------------------
  // Read-clear and set masks for the event registers
  // -------------------------------------------------------------
  // A read clears only what it returned, never a neighbouring bit
  wire             clear_all  = wr & hit_clear;
  wire [REG_W-1:0] esr_rdclr  = (rd & hit_esr) ? 8'hFF :
                                (rd & w_esr & idx_valid) ? idx_onehot : 8'h00;
  wire [REG_W-1:0] comm_error_event_reg_rdclr = (rd & hit_comm_error_event_reg) ? 8'hFF :
                                (rd & w_comm_error_event_reg & idx_valid) ? idx_onehot : 8'h00;
  // Clear-status covers every bit of both event registers
  wire [REG_W-1:0] esr_clr    = clear_all ? 8'hFF : esr_rdclr;
  wire [REG_W-1:0] comm_error_event_reg_clr   = clear_all ? 8'hFF : comm_error_event_reg_rdclr;
  // Arriving events win over a clear in the same cycle
  // An event lost to a clear in flight would never be reported
  wire [REG_W-1:0] next_esr   = (std_event_reg & ~esr_clr) | std_event_i;
  wire [REG_W-1:0] next_comm_error_event_reg  = (comm_error_event_reg & ~comm_error_event_reg_clr) | comm_event_i;

  // -------------------------------------------------------------
  // Mask writes, whole or per bit
  // -------------------------------------------------------------
  // A per-bit write changes the selected bit and keeps the other seven
  wire [REG_W-1:0] next_sre  = (wr & hit_sre) ? wb_dat_i[REG_W-1:0] :
                               (wr & w_sre)   ? ((sre_mask & ~idx_onehot) | (wr_bit ? idx_onehot : 8'h00)) :
                               sre_mask;
  wire [REG_W-1:0] next_ese  = (wr & hit_ese) ? wb_dat_i[REG_W-1:0] :
                               (wr & w_ese)   ? ((std_event_mask & ~idx_onehot) | (wr_bit ? idx_onehot : 8'h00)) :
                               std_event_mask;
  wire [REG_W-1:0] next_comm_error_event_mask = (wr & hit_comm_error_event_mask) ? wb_dat_i[REG_W-1:0] :
                               (wr & w_comm_error_event_mask)   ? ((comm_error_event_mask & ~idx_onehot) |
                                                  (wr_bit ? idx_onehot : 8'h00)) :
                               comm_error_event_mask;
  // Only bit 0 of the data is kept; the field has two values
  wire             next_pulse_mode = (wr & hit_pulse) ? wb_dat_i[0] : request_pulse_mode;

  // -------------------------------------------------------------
  // Read data selection
  // -------------------------------------------------------------
  // Hits are mutually exclusive, so the chain order carries no priority
  logic [REG_W-1:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_status) begin
      rd_byte = status_byte;
    end else if (hit_sre) begin
      rd_byte = sre_mask;
    end else if (hit_esr) begin
      rd_byte = std_event_reg;
    end else if (hit_ese) begin
      rd_byte = std_event_mask;
    end else if (hit_comm_error_event_reg) begin
      rd_byte = comm_error_event_reg;
    end else if (hit_comm_error_event_mask) begin
      rd_byte = comm_error_event_mask;
    end else if (hit_pulse) begin
      rd_byte = {7'h00, request_pulse_mode};
    end else if (w_status) begin
      rd_byte = {7'h00, status_byte[bit_idx]};
    end else if (w_esr) begin
      rd_byte = {7'h00, std_event_reg[bit_idx]};
    end else if (w_comm_error_event_reg) begin
      rd_byte = {7'h00, comm_error_event_reg[bit_idx]};
    end else if (w_sre) begin
      rd_byte = {7'h00, sre_mask[bit_idx]};
    end else if (w_ese) begin
      rd_byte = {7'h00, std_event_mask[bit_idx]};
    end else if (w_comm_error_event_mask) begin
      rd_byte = {7'h00, comm_error_event_mask[bit_idx]};
    end
  end

  // -------------------------------------------------------------
  // Service request sequencing
  // -------------------------------------------------------------
  // Idle: line high. Latch: line low until a whole status read.
  // Pulse: line low for PULSE_LEN cycles, then back to idle.
  // The output flop follows the next state, so the line moves
  // one cycle after the event that causes it.
  // Only the whole-byte read releases; the indexed window never does
  wire stb_release = rd & hit_status;
  wire pulse_last  = (pulse_cnt == PULSE_CNT_W'(PULSE_LEN - 1));

  always_comb begin
    next_req_state = req_state;
    next_pulse_cnt = pulse_cnt;
    case (req_state)
      SRU_REQ_IDLE: begin
        // Pulse mode starts the timer from zero
        if (new_req && request_pulse_mode) begin
          next_req_state = SRU_REQ_PULSE;
          next_pulse_cnt = '0;
        end else if (new_req) begin
          next_req_state = SRU_REQ_LATCH;
        end
      end
      SRU_REQ_LATCH: begin
        // A request arriving with the release keeps the line low
        if (stb_release && !new_req) begin
          next_req_state = SRU_REQ_IDLE;
        end
      end
      SRU_REQ_PULSE: begin
        // Rises seen now are absorbed by armed_q and never served
        if (pulse_last) begin
          next_req_state = SRU_REQ_IDLE;
        end else begin
          next_pulse_cnt = pulse_cnt + PULSE_CNT_W'(1);
        end
      end
      default: begin
        // Unused code: release the line
        next_req_state = SRU_REQ_IDLE;
      end
    endcase
  end

  // Low in both active states
  wire next_srq_n = (next_req_state == SRU_REQ_IDLE);

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  // Event and mask storage; all clear together on reset, so no stale
  // request survives it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sre_mask              <= RST_MASK;
      std_event_reg         <= RST_MASK;
      std_event_mask        <= RST_MASK;
      comm_error_event_reg  <= RST_MASK;
      comm_error_event_mask <= RST_MASK;
      request_pulse_mode    <= RST_PULSE;
      armed_q               <= RST_MASK;
    end else begin
      sre_mask              <= next_sre;
      std_event_reg         <= next_esr;
      std_event_mask        <= next_ese;
      comm_error_event_reg  <= next_comm_error_event_reg;
      comm_error_event_mask <= next_comm_error_event_mask;
      request_pulse_mode    <= next_pulse_mode;
      armed_q               <= armed;
    end
  end

  // Request line and pulse timer
  // The line comes from a flop, so no decode glitch reaches the host
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_state           <= SRU_REQ_IDLE;
      pulse_cnt           <= '0;
      service_request_n_o <= 1'b1;
    end else begin
      req_state           <= next_req_state;
      pulse_cnt           <= next_pulse_cnt;
      service_request_n_o <= next_srq_n;
    end
  end

  // Bus answer: one wait state, unmapped addresses read zero
  // Ack rises the cycle after the access is taken and drops the next;
  // read data holds until the next read, so a slow master still sees it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= take;
      if (rd) begin
        wb_dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Mode is mirrored out for the panel
  // Follows the written value in the same cycle as the internal bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      request_pulse_mode_o <= RST_PULSE;
    end else begin
      request_pulse_mode_o <= next_pulse_mode;
    end
  end

endmodule // sru_top

`default_nettype wire

// file: tb/sru_checker.sv
`timescale 1ns/1ns
`default_nettype none
module sru_checker
  import sru_pkg::*;
#(
  parameter int unsigned PULSE_LEN = sru_pkg::PULSE_CYCLES
)(
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [sru_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [sru_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic [sru_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire logic [sru_pkg::REG_W-1:0] dev_status_i,
  input wire logic [sru_pkg::REG_W-1:0] std_event_i,
  input wire logic [sru_pkg::REG_W-1:0] comm_event_i,
  input wire logic                      service_request_n_o,
  input wire logic                      request_pulse_mode_o
);
  // ---------------------------------------------------------------
  // Accepted bus cycles
  // ---------------------------------------------------------------
  wire logic taken = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic rd00  = taken & ~wb_we_i & (wb_adr_i == OFF_STATUS);
  wire logic wr18  = taken & wb_we_i & wb_sel_i[0] & (wb_adr_i == OFF_PULSE);
  wire logic bitrd = taken & ~wb_we_i & (wb_adr_i[7:5] != 3'h0) & (wb_adr_i[7:5] != 3'h7);
  wire logic quiet = (std_event_i == 8'h00) & (comm_event_i == 8'h00);
  logic [7:0] low_cnt;
  logic       pm_exp;

  // Low-time counter; reset too, so a pulse cut by reset never leaks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt <= 8'h00;
      pm_exp  <= 1'b0;
    end else begin
      low_cnt <= service_request_n_o ? 8'h00 : low_cnt + 8'h01;
      if (wr18) pm_exp <= wb_dat_i[0];
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence ack_seq;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  ack_once_a: assert property (taken |=> ack_seq)
    else $error("ack not a single pulse after request");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  read_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  bit_read_a: assert property (bitrd |=> wb_dat_o[31:1] == 31'h0)
    else $error("bit read wider than one bit");
  status_release_a: assert property (rd00 && quiet && $past(quiet) && $past(quiet, 2) &&
      $stable(dev_status_i) && !request_pulse_mode_o |-> ##2 service_request_n_o)
    else $error("status read did not release request");
  latch_hold_a: assert property ($rose(service_request_n_o) && !request_pulse_mode_o |-> $past(rd00))
    else $error("latched request released without status read");
  pulse_len_a: assert property ($rose(service_request_n_o) && request_pulse_mode_o |-> int'(low_cnt) == PULSE_LEN)
    else $error("request pulse length wrong");
  pulse_max_a: assert property (request_pulse_mode_o && !service_request_n_o |-> int'(low_cnt) < PULSE_LEN)
    else $error("request pulse too long");
  reset_mode_a: assert property ($fell(rst_i) |-> !request_pulse_mode_o && service_request_n_o && !wb_ack_o)
    else $error("reset state wrong");
  mode_write_a: assert property (wr18 |-> ##2 request_pulse_mode_o == pm_exp)
    else $error("pulse mode not written");
endmodule // sru_checker

bind sru_top sru_checker #(.PULSE_LEN(PULSE_LEN)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .dev_status_i(dev_status_i), .std_event_i(std_event_i),
  .comm_event_i(comm_event_i), .service_request_n_o(service_request_n_o),
  .request_pulse_mode_o(request_pulse_mode_o)
);
`default_nettype wire

// file: tb/sru_evt_src.sv
`timescale 1ns/1ns
`default_nettype none
module sru_evt_src (
  input  wire logic       clk_i,
  input  wire logic       fire_i,
  input  wire logic [7:0] std_i,
  input  wire logic [7:0] comm_i,
  output var  logic [7:0] std_event_o,
  output var  logic [7:0] comm_event_o
);
  // Instrument side: one-cycle event strobes, quiet otherwise
  always @(posedge clk_i) begin
    std_event_o  <= fire_i ? std_i : 8'h00;
    comm_event_o <= fire_i ? comm_i : 8'h00;
  end
endmodule // sru_evt_src
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sru_pkg::*;
  localparam int unsigned PL = 4;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [3:0]  bsel = 4'h1;
  logic [31:0] dat = 32'h0;
  logic [7:0]  dev = 8'h00;
  logic        fire = 1'b0;
  logic [7:0]  f_std = 8'h00;
  logic [7:0]  f_comm = 8'h00;
  logic [31:0] dat_o, q;
  logic        ack, srq_n, pm;
  logic [7:0]  std_ev, comm_ev, v;
  logic [7:0]  offs[3] = '{OFF_SRE, OFF_ESE, OFF_COMM_ERROR_EVENT_MASK};
  logic [7:0]  wins[3] = '{8'h80, 8'hA0, 8'hC0};
  logic [7:0]  eoff[2] = '{OFF_ESR, OFF_COMM_ERROR_EVENT_REG};
  logic [7:0]  ewin[2] = '{8'h40, 8'h60};
  int          n_mismatch = 0;
  int          checked = 0;
  int          i, k, cnt;

  always #4 clk_i = ~clk_i;

  sru_top #(.PULSE_LEN(PL)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .dev_status_i(dev),
    .std_event_i(std_ev), .comm_event_i(comm_ev), .service_request_n_o(srq_n),
    .request_pulse_mode_o(pm)
  );
  sru_evt_src src (
    .clk_i(clk_i), .fire_i(fire), .std_i(f_std), .comm_i(f_comm),
    .std_event_o(std_ev), .comm_event_o(comm_ev)
  );

  // ---------------------------------------------------------------
  // Bus, stimulus and compare helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] bit_adr(logic [7:0] base, int n);
    return base + 8'(4 * (n & 7));
  endfunction
  function automatic logic [31:0] exp_bit(logic [7:0] r, int n);
    return {31'h0, r[n]};
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= bsel;
    adr <= a;
    dat <= d;
    // Wait as long as the answer takes; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ev(input logic [7:0] s, input logic [7:0] c);
    f_std <= s;
    f_comm <= c;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    k = $urandom(19543);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    v = 8'($urandom);
    dev <= v;
    chk({31'h0, pm}, 32'h0);
    bus(1'b0, OFF_STATUS, 32'h0, q);
    chk(q, {24'h0, v & 8'h97});
    for (i = 1; i < 7; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0, q);
      chk(q, 32'h0);
    end
    bus(1'b0, 8'hE4, 32'h0, q);
    chk(q, 32'h0);
    dev <= 8'h00;
    $display("reset test done");
    // Enable masks, whole and per bit, with random contents
    for (k = 0; k < 3; k++) begin
      v = 8'($urandom);
      i = $urandom_range(7);
      bus(1'b1, offs[k], {24'h0, v}, q);
      bus(1'b0, offs[k], 32'h0, q);
      chk(q, {24'h0, v});
      for (cnt = 0; cnt < 8; cnt++) begin
        bus(1'b0, bit_adr(wins[k], cnt), 32'h0, q);
        chk(q, exp_bit(v, cnt));
      end
      bus(1'b1, bit_adr(wins[k], i), {31'h0, ~v[i]}, q);
      bus(1'b0, offs[k], 32'h0, q);
      chk(q, {24'h0, v ^ (8'h01 << i)});
      bus(1'b1, offs[k], 32'h0, q);
    end
    // A write with byte lane 0 off must leave the mask alone
    bsel = 4'hE;
    bus(1'b1, OFF_SRE, 32'hFF, q);
    bsel = 4'h1;
    bus(1'b0, OFF_SRE, 32'h0, q);
    chk(q, 32'h0);
    $display("mask test done");
    // Event registers: bit read clears one bit, whole read the rest
    for (k = 0; k < 2; k++) begin
      v = 8'($urandom);
      i = $urandom_range(7);
      if (k == 0) ev(v, 8'h00);
      else ev(8'h00, v);
      repeat (2) @(posedge clk_i);
      bus(1'b0, bit_adr(ewin[k], i), 32'h0, q);
      chk(q, exp_bit(v, i));
      bus(1'b0, bit_adr(ewin[k], i), 32'h0, q);
      chk(q, 32'h0);
      bus(1'b0, eoff[k], 32'h0, q);
      chk(q, {24'h0, v & ~(8'h01 << i)});
      bus(1'b0, eoff[k], 32'h0, q);
      chk(q, 32'h0);
    end
    ev(8'hFF, 8'hFF);
    bus(1'b1, OFF_CLEAR, 32'h1, q);
    bus(1'b0, OFF_ESR, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, OFF_COMM_ERROR_EVENT_REG, 32'h0, q);
    chk(q, 32'h0);
    $display("event test done");
    // Summary bits and latched request
    bus(1'b1, OFF_ESE, 32'h1, q);
    bus(1'b1, OFF_COMM_ERROR_EVENT_MASK, 32'h1, q);
    bus(1'b1, OFF_SRE, 32'h28, q);
    ev(8'h02, 8'h00);
    repeat (6) @(posedge clk_i);
    chk({31'h0, srq_n}, 32'h1);
    bus(1'b0, OFF_ESR, 32'h0, q);
    for (k = 0; k < 2; k++) begin
      if (k == 0) ev(8'h01, 8'h00);
      else ev(8'h00, 8'h01);
      repeat (6) @(posedge clk_i);
      chk({31'h0, srq_n}, 32'h0);
      bus(1'b0, bit_adr(8'h20, k == 0 ? 5 : 3), 32'h0, q);
      chk(q, 32'h1);
      repeat (4) @(posedge clk_i);
      chk({31'h0, srq_n}, 32'h0);
      bus(1'b0, OFF_STATUS, 32'h0, q);
      chk(q & 32'h28, k == 0 ? 32'h20 : 32'h08);
      repeat (3) @(posedge clk_i);
      chk({31'h0, srq_n}, 32'h1);
      bus(1'b0, eoff[k], 32'h0, q);
    end
    $display("latch test done");
    // Pulse mode: each new request raised while idle gives one pulse of fixed length
    bus(1'b1, OFF_PULSE, 32'h1, q);
    chk({31'h0, pm}, 32'h1);
    bus(1'b0, OFF_PULSE, 32'h0, q);
    chk(q, 32'h1);
    for (k = 0; k < 2; k++) begin
      ev(8'h01, 8'h00);
      cnt = 0;
      repeat (20) begin
        @(posedge clk_i);
        if (srq_n === 1'b0) cnt++;
      end
      chk(32'(cnt), 32'(PL));
      bus(1'b0, OFF_ESR, 32'h0, q);
    end
    bus(1'b1, OFF_PULSE, 32'h0, q);
    bus(1'b0, OFF_PULSE, 32'h0, q);
    chk(q, 32'h0);
    $display("pulse test done");
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
